// *** src/hfc_option_ctrl.v ***
// hdlc frame option control: mode and protocol option decode
//
// Summary of operation
// - mode bits 15:11 set minimum transmit flags
// - spacing code decoded by fixed lookup table
// - bit 7 extended control, needs extraction, not promiscuous
// - bit 6 extended address, same qualification
// - bit 5 low: strip and check receive FCS
// - bit 5 high: strip 16/32 bits, no check
// - unchecked even-length frame appends first 16 bits
// - bit 4 low: transmitter generates and appends FCS
// - bit 4 high: no FCS generated on transmit
// - bit 3 high 16-bit FCS, low 32-bit
// - loopback field zero means normal operation
// - loopback 4 loops data and external transmit clock
// - loopback 5 loops data, system clock/8
// - loopback 6 like 4, data pin held high
// - loopback 7 like 5, data pin held high
// - SIM frames recognised only when bit 7 set
// - CFGR frames recognised only when bit 5 set
// - UP frames recognised only when bit 4 set
// - TEST frames recognised only when bit 3 set
// - promiscuous mode drops address and extended field filtering; type enables still apply
`timescale 1ns/100ps
`include "hfc_defs.vh"
module hfc_option_ctrl (
  input  wire        clk,                 // system clock, 40 MHz
  input  wire        rst_n,               // synchronous reset, active low
  input  wire        ce,                  // clock enable, freezes all state
  // init block word fetch
  input  wire        init_word_valid,     // fetched word strobe
  input  wire [7:0]  init_word_offset,    // byte offset in init block
  input  wire [15:0] init_word_data,      // fetched word
  // host mode control bit
  input  wire        promiscuous_accept,  // accept all, no address or extended field filtering
  // transmit framing
  input  wire        tx_frame_end,        // closing flag of a frame sent
  input  wire        tx_flag_sent,        // one flag sent between frames
  input  wire        tx_bit,              // serial bit from transmitter
  // receive framing
  input  wire        rx_frame_end,        // received frame complete
  input  wire [15:0] rx_byte_count,       // byte count of that frame
  input  wire        rx_type_valid,       // frame type decoded strobe
  input  wire [1:0]  rx_type,             // decoded frame type
  // serial pins
  input  wire        tx_clk_pin,          // external transmit clock
  input  wire        rx_clk_pin,          // external receive clock
  input  wire        rx_data_pin,         // external receive data
  output reg         tx_data_pin,         // serial transmit data pin
  // serial timing to framers
  output reg         tx_bit_tick,         // transmitter shift enable
  output reg         rx_bit_tick,         // receiver sample enable
  output reg         rx_bit,              // bit presented to receiver
  // decoded configuration
  output reg  [5:0]  min_flag_count,      // decoded minimum flags
  output reg         tx_gap_ok,           // enough flags since last frame
  output reg         ext_ctrl_filter_en,  // extended control filtering
  output reg         ext_addr_filter_en,  // extended address filtering
  output reg         ext_ctrl_force,      // force two-octet control
  output reg         ext_addr_force,      // force two-octet address
  output reg         field_extract_disable, // fields kept as data
  output reg         accept_all,          // no address filtering
  output reg         rx_check_en,         // verify received FCS
  output reg  [5:0]  rx_strip_bits,       // FCS bits removed per frame
  output reg         rx_append16,         // pulse: append 16 FCS bits
  output reg         tx_check_en,         // generate and append FCS
  output reg         check_width_16,      // 16-bit FCS selected
  output reg  [2:0]  loopback_select,     // loopback code in force
  output reg         sim_frame_en,        // SIM recognition enable
  output reg         cfgr_frame_en,       // CFGR recognition enable
  output reg         up_frame_en,         // UP recognition enable
  output reg         test_frame_en,       // TEST recognition enable
  output reg         rx_type_accept       // pulse: decoded type accepted
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg  [15:0] mode_ff;                    // operating mode word
  reg  [15:0] proto_ff;                   // protocol options word
  reg  [2:0]  div_ff;                     // system clock divide-by-8 phase
  reg  [5:0]  flags_ff;                   // flags sent since frame end
  reg  [1:0]  clk_hist_ff;                // previous synced clock levels
  wire [2:0]  pin_sync;                   // synced clocks and data
  wire        tx_clk_s;                   // synced transmit clock
  wire        rx_clk_s;                   // synced receive clock
  wire        rx_data_s;                  // synced receive data
  wire        tx_clk_rise;                // external transmit clock edge
  wire        rx_clk_rise;                // external receive clock edge
  wire        div_tick;                   // one pulse every 8 clocks
  wire [2:0]  lb;                         // loopback field
  wire        lb_internal;                // data looped internally
  wire        lb_divclk;                  // clocks from divider
  wire        lb_silent;                  // data pin held high
  wire        filt_ok;                    // extraction on, not promiscuous
  wire [5:0]  nxt_min_flags;              // decoded spacing code
  reg  [5:0]  nxt_flags;                  // next flag count
  reg         nxt_type_ok;                // type enable lookup
  wire        nxt_tx_tick;                // next transmit tick
  wire        nxt_rx_tick;                // next receive tick

  // ------------------------------------------------------------
  // spacing code to flag count lookup
  // ------------------------------------------------------------
  function [5:0] spc_decode;
    input [4:0] code;
    begin
      case (code)
        5'h00: spc_decode = 6'h02;
        5'h01: spc_decode = 6'h01;
        5'h02: spc_decode = 6'h04;
        5'h03: spc_decode = 6'h26;
        5'h04: spc_decode = 6'h06;
        5'h05: spc_decode = 6'h0C;
        5'h06: spc_decode = 6'h28;
        5'h07: spc_decode = 6'h18;
        5'h08: spc_decode = 6'h3C;
        5'h09: spc_decode = 6'h08;
        5'h0A: spc_decode = 6'h38;
        5'h0B: spc_decode = 6'h0E;
        5'h0C: spc_decode = 6'h12;
        5'h0D: spc_decode = 6'h2A;
        5'h0E: spc_decode = 6'h30;
        5'h0F: spc_decode = 6'h1A;
        5'h10: spc_decode = 6'h3E;
        5'h11: spc_decode = 6'h24;
        5'h12: spc_decode = 6'h0A;
        5'h13: spc_decode = 6'h16;
        5'h14: spc_decode = 6'h3A;
        5'h15: spc_decode = 6'h36;
        5'h16: spc_decode = 6'h10;
        5'h17: spc_decode = 6'h2E;
        5'h18: spc_decode = 6'h22;
        5'h19: spc_decode = 6'h14;
        5'h1A: spc_decode = 6'h34;
        5'h1B: spc_decode = 6'h2C;
        5'h1C: spc_decode = 6'h20;
        5'h1D: spc_decode = 6'h32;
        5'h1E: spc_decode = 6'h1E;
        5'h1F: spc_decode = 6'h1C;
        default: spc_decode = 6'h02;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  hfc_sync #(
    .W (3)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({rx_data_pin, rx_clk_pin, tx_clk_pin}),
    .q     (pin_sync)
  );

  assign tx_clk_s  = pin_sync[0];
  assign rx_clk_s  = pin_sync[1];
  assign rx_data_s = pin_sync[2];

  // ------------------------------------------------------------
  // init block word capture
  // ------------------------------------------------------------
  // only the two option words are kept; other offsets are ignored
  always @(posedge clk) begin
    if (!rst_n) begin
      mode_ff  <= `HFC_MODE_RST;
      proto_ff <= `HFC_PROTO_RST;
    end else if (ce && init_word_valid) begin
      if (init_word_offset == `HFC_OFS_MODE) begin
        mode_ff <= init_word_data;
      end
      if (init_word_offset == `HFC_OFS_PROTO) begin
        proto_ff <= init_word_data & 16'h00B8;
      end
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  // non-linear spacing table
  assign nxt_min_flags =
    spc_decode(mode_ff[`HFC_MODE_SPC_HI:`HFC_MODE_SPC_LO]);
  assign filt_ok = ~mode_ff[`HFC_MODE_DISEXT] & ~promiscuous_accept;
  assign lb      = mode_ff[`HFC_MODE_LB_HI:`HFC_MODE_LB_LO];
  // codes below 4 leave the paths normal
  assign lb_internal = lb[2];
  // divided system clock for 5 and 7
  assign lb_divclk = (lb == `HFC_LB_CLKLESS) ||
                     (lb == `HFC_LB_SIL_CLKLESS);
  assign lb_silent = (lb == `HFC_LB_SILENT) ||
                     (lb == `HFC_LB_SIL_CLKLESS);

  // ------------------------------------------------------------
  // divide-by-8 clock source and pin clock edges
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      div_ff      <= 3'h0;
      clk_hist_ff <= 2'h0;
    end else if (ce) begin
      div_ff      <= div_ff + 3'h1;
      clk_hist_ff <= {rx_clk_s, tx_clk_s};
    end
  end

  assign div_tick    = ({1'b0, div_ff} == (`HFC_SYS_CLK_DIV - 4'h1));
  assign tx_clk_rise = tx_clk_s & ~clk_hist_ff[0];
  assign rx_clk_rise = rx_clk_s & ~clk_hist_ff[1];
  assign nxt_tx_tick = lb_divclk ? div_tick : tx_clk_rise;
  assign nxt_rx_tick = lb_divclk   ? div_tick :
                       lb_internal ? tx_clk_rise : rx_clk_rise;

  // ------------------------------------------------------------
  // serial path steering
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      tx_data_pin <= 1'b1;
      rx_bit      <= 1'b1;
      tx_bit_tick <= 1'b0;
      rx_bit_tick <= 1'b0;
    end else if (ce) begin
      // data pin held high when silent
      tx_data_pin <= lb_silent ? 1'b1 : tx_bit;
      // internal data loop for codes 4 to 7
      rx_bit      <= lb_internal ? tx_bit : rx_data_s;
      tx_bit_tick <= nxt_tx_tick;
      rx_bit_tick <= nxt_rx_tick;
    end
  end

  // ------------------------------------------------------------
  // inter-frame flag counting
  // ------------------------------------------------------------
  always @* begin
    nxt_flags = flags_ff;
    if (tx_frame_end) begin
      nxt_flags = 6'h00;
    end else if (tx_flag_sent && flags_ff != 6'h3F) begin
      nxt_flags = flags_ff + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // frame type enable lookup
  // ------------------------------------------------------------
  always @* begin
    case (rx_type)
      `HFC_TYPE_SIM:  nxt_type_ok = proto_ff[`HFC_PROTO_SIM];
      `HFC_TYPE_CFGR: nxt_type_ok = proto_ff[`HFC_PROTO_CFGR];
      `HFC_TYPE_UP:   nxt_type_ok = proto_ff[`HFC_PROTO_UP];
      `HFC_TYPE_TEST: nxt_type_ok = proto_ff[`HFC_PROTO_TEST];
      default:        nxt_type_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // registered configuration outputs
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      flags_ff              <= 6'h00;
      min_flag_count        <= 6'h02;
      tx_gap_ok             <= 1'b0;
      ext_ctrl_filter_en    <= 1'b0;
      ext_addr_filter_en    <= 1'b0;
      ext_ctrl_force        <= 1'b0;
      ext_addr_force        <= 1'b0;
      field_extract_disable <= 1'b0;
      accept_all            <= 1'b0;
      rx_check_en           <= 1'b1;
      rx_strip_bits         <= `HFC_CHECK_BITS_32;
      rx_append16           <= 1'b0;
      tx_check_en           <= 1'b1;
      check_width_16        <= 1'b0;
      loopback_select       <= `HFC_LB_NORMAL;
      sim_frame_en          <= 1'b0;
      cfgr_frame_en         <= 1'b0;
      up_frame_en           <= 1'b0;
      test_frame_en         <= 1'b0;
      rx_type_accept        <= 1'b0;
    end else if (ce) begin
      flags_ff              <= nxt_flags;
      min_flag_count        <= nxt_min_flags;
      tx_gap_ok             <= (nxt_flags >= nxt_min_flags);
      ext_ctrl_filter_en    <= mode_ff[`HFC_MODE_XCTL] & filt_ok;
      ext_addr_filter_en    <= mode_ff[`HFC_MODE_XADR] & filt_ok;
      ext_ctrl_force        <= mode_ff[`HFC_MODE_XCTLF] &
                               mode_ff[`HFC_MODE_XCTL] & filt_ok;
      ext_addr_force        <= mode_ff[`HFC_MODE_XADRF] &
                               mode_ff[`HFC_MODE_XADR] & filt_ok;
      field_extract_disable <= mode_ff[`HFC_MODE_DISEXT];
      accept_all            <= promiscuous_accept;
      // check enabled while bit 5 low
      rx_check_en           <= ~mode_ff[`HFC_MODE_RXDIS];
      rx_strip_bits         <= mode_ff[`HFC_MODE_WIDTH] ?
                               `HFC_CHECK_BITS_16 : `HFC_CHECK_BITS_32;
      rx_append16           <= rx_frame_end &
                               mode_ff[`HFC_MODE_RXDIS] &
                               ~rx_byte_count[0];
      // generator on while bit 4 low
      // generator off while bit 4 high
      tx_check_en           <= ~mode_ff[`HFC_MODE_TXDIS];
      check_width_16        <= mode_ff[`HFC_MODE_WIDTH];
      loopback_select       <= lb;
      sim_frame_en          <= proto_ff[`HFC_PROTO_SIM];
      cfgr_frame_en         <= proto_ff[`HFC_PROTO_CFGR];
      up_frame_en           <= proto_ff[`HFC_PROTO_UP];
      test_frame_en         <= proto_ff[`HFC_PROTO_TEST];
      rx_type_accept        <= rx_type_valid & nxt_type_ok;
    end
  end

endmodule

// *** common/hfc_defs.vh ***
// constants for the hdlc frame option control block
`ifndef HFC_DEFS_VH
`define HFC_DEFS_VH

// ------------------------------------------------------------
// init block word offsets (bytes from init block base)
// ------------------------------------------------------------
`define HFC_OFS_MODE        8'h00
`define HFC_OFS_PROTO       8'h0C

// ------------------------------------------------------------
// operating mode word fields
// ------------------------------------------------------------
`define HFC_MODE_SPC_HI     15
`define HFC_MODE_SPC_LO     11
`define HFC_MODE_XCTLF      10
`define HFC_MODE_XADRF      9
`define HFC_MODE_DISEXT     8
`define HFC_MODE_XCTL       7
`define HFC_MODE_XADR       6
`define HFC_MODE_RXDIS      5
`define HFC_MODE_TXDIS      4
`define HFC_MODE_WIDTH      3
`define HFC_MODE_LB_HI      2
`define HFC_MODE_LB_LO      0

// ------------------------------------------------------------
// protocol options word fields
// ------------------------------------------------------------
`define HFC_PROTO_SIM       7
`define HFC_PROTO_CFGR      5
`define HFC_PROTO_UP        4
`define HFC_PROTO_TEST      3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define HFC_MODE_RST        16'h0000
`define HFC_PROTO_RST       16'h0000

// ------------------------------------------------------------
// loopback codes and received frame type codes
// ------------------------------------------------------------
`define HFC_LB_NORMAL       3'h0
`define HFC_LB_SIMPLE       3'h4
`define HFC_LB_CLKLESS      3'h5
`define HFC_LB_SILENT       3'h6
`define HFC_LB_SIL_CLKLESS  3'h7
`define HFC_TYPE_SIM        2'h0
`define HFC_TYPE_CFGR       2'h1
`define HFC_TYPE_UP         2'h2
`define HFC_TYPE_TEST       2'h3

// ------------------------------------------------------------
// timing and widths
// ------------------------------------------------------------
`define HFC_SYS_CLK_DIV     4'h8
`define HFC_CHECK_BITS_16   6'h10
`define HFC_CHECK_BITS_32   6'h20

`endif

// *** src/hfc_sync.v ***
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/100ps
module hfc_sync #(
  parameter W = 1                      // number of bits synchronised
) (
  input  wire         clk,             // system clock
  input  wire         rst_n,           // synchronous reset, active low
  input  wire         ce,              // clock enable
  input  wire [W-1:0] d,               // asynchronous level in
  output wire [W-1:0] q                // synchronised level out
);
  reg [W-1:0] meta_ff;                 // first stage, read only by second
  reg [W-1:0] sync_ff;                 // second stage
  genvar i;

  // ------------------------------------------------------------
  // one bit pair per input bit
  // ------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!rst_n) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else if (ce) begin
          meta_ff[i] <= d[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign q = sync_ff;
endmodule

// *** sim/hfc_chk.sv ***
// assertion checker for the option control block
`timescale 1ns/100ps
module hfc_chk (
  input logic       clk,
  input logic       rst_n,
  input logic       promiscuous_accept,
  input logic       tx_frame_end,
  input logic       tx_gap_ok,
  input logic       tx_bit,
  input logic       tx_data_pin,
  input logic       rx_frame_end,
  input logic [15:0] rx_byte_count,
  input logic       rx_type_valid,
  input logic [1:0] rx_type,
  input logic       rx_bit,
  input logic       rx_bit_tick,
  input logic       rx_check_en,
  input logic [5:0] rx_strip_bits,
  input logic       rx_append16,
  input logic       check_width_16,
  input logic [2:0] loopback_select,
  input logic       ext_ctrl_filter_en,
  input logic       ext_addr_filter_en,
  input logic       field_extract_disable,
  input logic       accept_all,
  input logic       sim_frame_en,
  input logic       cfgr_frame_en,
  input logic       up_frame_en,
  input logic       test_frame_en,
  input logic       rx_type_accept
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] type_en = {test_frame_en, up_frame_en, cfgr_frame_en,
                        sim_frame_en};         // enables by type code
  wire       sel_en  = type_en[rx_type];       // enable of offered type
  wire       cnt_even = ~rx_byte_count[0];     // even frame length
  wire       lb_int  = loopback_select[2];     // internal data loop
  wire       clkless = loopback_select[2] & loopback_select[0];

  property p_gap; tx_frame_end |=> !tx_gap_ok; endproperty
  a_gap: assert property (p_gap) else $error("gap ok after frame end");
  property p_app;
    rx_frame_end && !rx_check_en && cnt_even |=> rx_append16;
  endproperty
  a_app: assert property (p_app) else $error("append missing");
  property p_noapp; rx_append16 |-> $past(rx_frame_end) && $past(cnt_even);
  endproperty
  a_noapp: assert property (p_noapp) else $error("append spurious");
  property p_strip;
    rx_strip_bits == (check_width_16 ? 6'h10 : 6'h20);
  endproperty
  a_strip: assert property (p_strip) else $error("strip width");
  property p_silent; loopback_select[2:1] == 2'b11 |-> tx_data_pin;
  endproperty
  a_silent: assert property (p_silent) else $error("data pin");
  property p_loop; lb_int && $past(lb_int) |-> rx_bit == $past(tx_bit);
  endproperty
  a_loop: assert property (p_loop) else $error("loop data");
  property p_div;
    clkless && rx_bit_tick |=> !rx_bit_tick [*7] ##1 (rx_bit_tick || !clkless);
  endproperty
  a_div: assert property (p_div) else $error("divide by 8");
  property p_type;
    rx_type_accept == ($past(rx_type_valid) && $past(sel_en));
  endproperty
  a_type: assert property (p_type) else $error("type accept");
  property p_filt;
    ext_ctrl_filter_en || ext_addr_filter_en |->
      !field_extract_disable && !accept_all;
  endproperty
  a_filt: assert property (p_filt) else $error("filter qual");
  property p_promiscuous_accept; $past(rst_n) |-> accept_all == $past(promiscuous_accept);
  endproperty
  a_promiscuous_accept: assert property (p_promiscuous_accept) else $error("accept all");
  c_app: cover property (rx_append16);
  c_div: cover property (clkless && rx_bit_tick);
  c_type: cover property (rx_type_accept);
endmodule
bind hfc_option_ctrl hfc_chk i_chk (.clk(clk), .rst_n(rst_n),
  .promiscuous_accept(promiscuous_accept), .tx_frame_end(tx_frame_end),
  .tx_gap_ok(tx_gap_ok), .tx_bit(tx_bit), .tx_data_pin(tx_data_pin),
  .rx_frame_end(rx_frame_end), .rx_byte_count(rx_byte_count),
  .rx_type_valid(rx_type_valid), .rx_type(rx_type), .rx_bit(rx_bit),
  .rx_bit_tick(rx_bit_tick), .rx_check_en(rx_check_en),
  .rx_strip_bits(rx_strip_bits), .rx_append16(rx_append16),
  .check_width_16(check_width_16), .loopback_select(loopback_select),
  .ext_ctrl_filter_en(ext_ctrl_filter_en),
  .ext_addr_filter_en(ext_addr_filter_en),
  .field_extract_disable(field_extract_disable), .accept_all(accept_all),
  .sim_frame_en(sim_frame_en), .cfgr_frame_en(cfgr_frame_en),
  .up_frame_en(up_frame_en), .test_frame_en(test_frame_en),
  .rx_type_accept(rx_type_accept));

// *** sim/hfc_peer.sv ***
// behavioural remote station driving the serial pins
`timescale 1ns/100ps
module hfc_peer (
  output logic tx_clk_pin,
  output logic rx_clk_pin,
  output logic rx_data_pin
);
  // clocks stand still low outside frames, line starts high
  initial begin
    tx_clk_pin = 1'b0;
    rx_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
  end
  task automatic burst(input logic [3:0] bits);
    int i;
    for (i = 0; i < 4; i++) begin
      rx_data_pin = bits[i];
      #113;
      tx_clk_pin = 1'b1;
      rx_clk_pin = 1'b1;
      #97;
      tx_clk_pin = 1'b0;
      rx_clk_pin = 1'b0;
    end
    // released line shows the inverse of the last bit
    rx_data_pin = ~bits[3];
  endtask
endmodule

// *** sim/testbench.sv ***
// self-checking testbench for the option control block
`timescale 1ns/100ps
module testbench;
  logic        clk, rst_n, init_word_valid, promiscuous_accept, tx_bit;
  logic        tx_frame_end, tx_flag_sent, rx_frame_end, rx_type_valid;
  logic [1:0]  rx_type;
  logic [7:0]  init_word_offset;
  logic [15:0] init_word_data, rx_byte_count;
  wire         tx_clk_pin, rx_clk_pin, rx_data_pin, tx_data_pin, rx_bit;
  wire         tx_bit_tick, rx_bit_tick, tx_gap_ok, rx_append16;
  wire         ext_ctrl_filter_en, ext_addr_filter_en, ext_ctrl_force;
  wire         ext_addr_force, field_extract_disable, accept_all;
  wire         rx_check_en, tx_check_en, check_width_16, rx_type_accept;
  wire         sim_frame_en, cfgr_frame_en, up_frame_en, test_frame_en;
  wire [5:0]   min_flag_count, rx_strip_bits;
  wire [2:0]   loopback_select;
  int          miscompares, n_compared, ntx, nrx, c, k;
  // flags for each spacing code
  localparam logic [5:0] flags_tab [32] = '{2, 1, 4, 38, 6, 12, 40, 24,
    60, 8, 56, 14, 18, 42, 48, 26, 62, 36, 10, 22, 58, 54, 16, 46, 34,
    20, 52, 44, 32, 50, 30, 28};
  localparam logic [2:0] lb_tab [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam int bit_pos [4] = '{7, 5, 4, 3};

  hfc_option_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .init_word_valid(init_word_valid), .init_word_offset(init_word_offset),
    .init_word_data(init_word_data), .promiscuous_accept(promiscuous_accept),
    .tx_frame_end(tx_frame_end), .tx_flag_sent(tx_flag_sent),
    .tx_bit(tx_bit), .rx_frame_end(rx_frame_end),
    .rx_byte_count(rx_byte_count), .rx_type_valid(rx_type_valid),
    .rx_type(rx_type), .tx_clk_pin(tx_clk_pin), .rx_clk_pin(rx_clk_pin),
    .rx_data_pin(rx_data_pin), .tx_data_pin(tx_data_pin),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick), .rx_bit(rx_bit),
    .min_flag_count(min_flag_count), .tx_gap_ok(tx_gap_ok),
    .ext_ctrl_filter_en(ext_ctrl_filter_en),
    .ext_addr_filter_en(ext_addr_filter_en),
    .ext_ctrl_force(ext_ctrl_force), .ext_addr_force(ext_addr_force),
    .field_extract_disable(field_extract_disable), .accept_all(accept_all),
    .rx_check_en(rx_check_en), .rx_strip_bits(rx_strip_bits),
    .rx_append16(rx_append16), .tx_check_en(tx_check_en),
    .check_width_16(check_width_16), .loopback_select(loopback_select),
    .sim_frame_en(sim_frame_en), .cfgr_frame_en(cfgr_frame_en),
    .up_frame_en(up_frame_en), .test_frame_en(test_frame_en),
    .rx_type_accept(rx_type_accept));
  hfc_peer i_peer (.tx_clk_pin(tx_clk_pin), .rx_clk_pin(rx_clk_pin),
    .rx_data_pin(rx_data_pin));

  always #12.5 clk = ~clk;
  // tick counters for the serial timing checks
  always @(posedge clk) begin
    if (tx_bit_tick === 1'b1) ntx++;
    if (rx_bit_tick === 1'b1) nrx++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // word fetch, outputs settled two edges after the take
  task automatic load(input logic [7:0] ofs, input logic [15:0] d);
    init_word_valid = 1'b1;
    init_word_offset = ofs;
    init_word_data = d;
    step(1);
    init_word_valid = 1'b0;
    step(2);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {clk, rst_n, init_word_valid, promiscuous_accept, tx_bit} = '0;
    {tx_frame_end, tx_flag_sent, rx_frame_end, rx_type_valid} = '0;
    {rx_type, init_word_offset, init_word_data, rx_byte_count} = '0;
    step(16);
    chk(min_flag_count, 16'h2);
    chk({rx_check_en, tx_check_en, check_width_16, tx_data_pin}, 16'hD);
    chk(loopback_select, 16'h0);
    rst_n = 1'b1;
    for (c = 0; c < 32; c++) begin
      load(8'h00, {c[4:0], 11'h000});
      chk(min_flag_count, flags_tab[c]);
    end
    load(8'h00, 16'h1000);
    tx_frame_end = 1'b1;
    step(1);
    tx_frame_end = 1'b0;
    for (c = 1; c <= 4; c++) begin
      tx_flag_sent = 1'b1;
      step(1);
      tx_flag_sent = 1'b0;
      step(1);
      chk(tx_gap_ok, c >= 4);
    end
    load(8'h00, 16'h06F8);
    chk({ext_ctrl_filter_en, ext_addr_filter_en}, 16'h3);
    chk({ext_ctrl_force, ext_addr_force, rx_check_en}, 16'h6);
    chk({tx_check_en, check_width_16, rx_strip_bits}, 16'h50);
    promiscuous_accept = 1'b1;
    step(2);
    chk({ext_ctrl_filter_en, ext_addr_filter_en, accept_all}, 16'h1);
    promiscuous_accept = 1'b0;
    load(8'h00, 16'h01C0);
    chk({ext_ctrl_filter_en, field_extract_disable}, 16'h1);
    chk({rx_check_en, tx_check_en, rx_strip_bits}, 16'hE0);
    load(8'h02, 16'hFFFF);
    chk({field_extract_disable, min_flag_count}, 16'h42);
    for (c = 0; c < 3; c++) begin
      load(8'h00, c < 2 ? 16'h0020 : 16'h0000);
      rx_byte_count = c == 1 ? 16'h0005 : 16'h0004;
      rx_frame_end = 1'b1;
      step(1);
      rx_frame_end = 1'b0;
      chk(rx_append16, c == 0);
      step(1);
    end
    for (c = 0; c < 4; c++) begin
      load(8'h0C, 16'h0001 << bit_pos[c]);
      chk({sim_frame_en, cfgr_frame_en, up_frame_en, test_frame_en},
          16'h8 >> c);
      for (k = 0; k < 4; k++) begin
        rx_type = k[1:0];
        rx_type_valid = 1'b1;
        step(1);
        rx_type_valid = 1'b0;
        chk(rx_type_accept, k == c);
        step(1);
      end
    end
    // reserved codes skipped, loops run without transmit check
    tx_bit = 1'b1;
    for (c = 0; c < 5; c++) begin
      load(8'h00, {13'h0, lb_tab[c]} | (c > 0 ? 16'h0010 : 16'h0000));
      chk({tx_check_en, loopback_select}, {c == 0, lb_tab[c]});
      chk(tx_data_pin, 16'h1);
      ntx = 0;
      nrx = 0;
      if (lb_tab[c][0])
        step(64);
      else begin
        i_peer.burst(4'hA);
        step(8);
      end
      chk(ntx, lb_tab[c][0] ? 16'h8 : 16'h4);
      chk(nrx, lb_tab[c][0] ? 16'h8 : 16'h4);
      chk(rx_bit, c > 0);
    end
    tx_bit = 1'b0;
    step(3);
    chk({tx_data_pin, rx_bit}, 16'h2);
    complete_run();
  end
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
endmodule
